// [verilog/mrie_exec.v]
// Execution of store, option, reset and return instructions
`timescale 1ns/1ps
`default_nettype none
`include "mrie_consts.vh"

module mrie_exec #(
  parameter PW  = 16,
  parameter DW  = 8,
  parameter PCW = 15,
  parameter AW  = 3
) (
  input  wire                core_clk,
  input  wire                rst,
  input  wire [`MRIE_IW-1:0] instr_word,
  input  wire                instr_valid,
  output wire                instr_ready,
  input  wire [DW-1:0]       w_reg,
  input  wire [PCW-1:0]      stack_top,
  output reg                 mem_wr_en,
  output reg  [PW-1:0]       mem_wr_addr,
  output reg  [DW-1:0]       mem_wr_data,
  output reg                 pc_advance,
  output reg                 pc_load,
  output reg  [PCW-1:0]      pc_value,
  output reg                 stack_pop,
  output reg                 soft_reset_req,
  output reg  [DW-1:0]       option_reg,
  output reg                 reset_instr_flag,
  output reg                 global_irq_enable,
  output wire [PW-1:0]       pointer_0,
  output wire [PW-1:0]       pointer_1,
  input  wire [AW-1:0]       reg_addr,
  input  wire [DW-1:0]       reg_wdata,
  input  wire                reg_wr,
  input  wire                reg_rd,
  output reg  [DW-1:0]       reg_rdata
);

  localparam HW = PW / 2;

  // Execution states of the return sequencer
  localparam [0:0] ST_RUN   = `MRIE_ST_RUN;
  localparam [0:0] ST_FLUSH = `MRIE_ST_FLUSH;

  // Step a pointer by one; the carry out is dropped on purpose
  function [PW-1:0] ptr_step;
    input [PW-1:0] p;
    input          dec;
    begin
      if (dec)
        ptr_step = p - {{(PW-1){1'b0}}, 1'b1};
      else
        ptr_step = p + {{(PW-1){1'b0}}, 1'b1};
    end
  endfunction

  // Pointer plus sign-extended offset, wrapping in the pointer width
  function [PW-1:0] ptr_offset;
    input [PW-1:0]         p;
    input [`MRIE_K_W-1:0]  k;
    begin
      ptr_offset = p + {{(PW-`MRIE_K_W){k[`MRIE_K_W-1]}}, k};
    end
  endfunction

  // Choose pointer 0 or 1 from a one-bit select operand
  function [PW-1:0] pick_ptr;
    input [PW-1:0] p0;
    input [PW-1:0] p1;
    input          sel;
    begin
      pick_ptr = sel ? p1 : p0;
    end
  endfunction

  // Sequencer state and the two live pointer values
  reg          state;
  wire [PW-1:0] ptr0;
  wire [PW-1:0] ptr1;

  assign pointer_0 = ptr0;
  assign pointer_1 = ptr1;

  // New instructions are held off during the second cycle of a return
  assign instr_ready = (state == ST_RUN);

  wire take = instr_valid && instr_ready;

  // Opcode decode
  wire is_dir = (instr_word & `MRIE_DIR_MASK) == `MRIE_DIR_MATCH;
  wire is_ind = (instr_word & `MRIE_IND_MASK) == `MRIE_IND_MATCH;
  wire is_rel = (instr_word & `MRIE_REL_MASK) == `MRIE_REL_MATCH;
  wire is_nop = instr_word == `MRIE_OP_NOP;
  wire is_opt = instr_word == `MRIE_OP_OPTION;
  wire is_swr = instr_word == `MRIE_OP_SWRESET;
  wire is_irt = instr_word == `MRIE_OP_IRQRET;
  wire is_srt = instr_word == `MRIE_OP_SUBRET;

  // Operand fields of the offered word
  wire [6:0] f_addr = instr_word[`MRIE_F_HI:0];
  wire [1:0] mode   = instr_word[`MRIE_MODE_HI:`MRIE_MODE_LO];
  wire       ind_n  = instr_word[`MRIE_IND_SEL_BIT];
  wire       rel_n  = instr_word[`MRIE_REL_SEL_BIT];
  wire [`MRIE_K_W-1:0] k_off = instr_word[`MRIE_K_HI:0];

  // Decode results for the store forms
  reg [PW-1:0] ea;
  reg          ea_we;
  reg          upd_we;
  reg          upd_idx;
  reg [PW-1:0] upd_val;
  reg [PW-1:0] sel_ptr;
  reg [PW-1:0] stepped;

  // Effective address and pointer update for the store forms
  always @* begin
    ea      = {PW{1'b0}};
    ea_we   = 1'b0;
    upd_we  = 1'b0;
    upd_idx = 1'b0;
    upd_val = {PW{1'b0}};
    sel_ptr = ptr0;
    stepped = ptr0;
    if (take && is_dir) begin
      ea_we = 1'b1;
      // Indirect data registers are aliases of the pointed location
      if (f_addr == `MRIE_IND0_ADDR)
        ea = ptr0;
      else if (f_addr == `MRIE_IND1_ADDR)
        ea = ptr1;
      else
        ea = {{(PW-7){1'b0}}, f_addr};
    end else if (take && is_ind) begin
      sel_ptr = pick_ptr(ptr0, ptr1, ind_n);
      // Mode bit 0 picks decrement, bit 1 picks post
      stepped = ptr_step(sel_ptr, mode[0]);
      ea_we   = 1'b1;
      upd_we  = 1'b1;
      upd_idx = ind_n;
      upd_val = stepped;
      case (mode)
        `MRIE_MODE_PREINC,
        `MRIE_MODE_PREDEC:  ea = stepped;
        `MRIE_MODE_POSTINC,
        `MRIE_MODE_POSTDEC: ea = sel_ptr;
        default:            ea = sel_ptr;
      endcase
    end else if (take && is_rel) begin
      sel_ptr = pick_ptr(ptr0, ptr1, rel_n);
      ea      = ptr_offset(sel_ptr, k_off);
      ea_we   = 1'b1;
    end
  end

  // Pointer port: instruction update wins over a register port write
  wire bus_ptr = reg_wr &&
                 (reg_addr == `MRIE_REG_PTR0_LO ||
                  reg_addr == `MRIE_REG_PTR0_HI ||
                  reg_addr == `MRIE_REG_PTR1_LO ||
                  reg_addr == `MRIE_REG_PTR1_HI);
  wire bus_idx = (reg_addr == `MRIE_REG_PTR1_LO) ||
                 (reg_addr == `MRIE_REG_PTR1_HI);
  wire bus_hi  = (reg_addr == `MRIE_REG_PTR0_HI) ||
                 (reg_addr == `MRIE_REG_PTR1_HI);

  wire          pf_we  = upd_we || bus_ptr;
  wire          pf_idx = upd_we ? upd_idx : bus_idx;
  wire [1:0]    pf_be  = upd_we ? 2'h3 : (bus_hi ? 2'h2 : 2'h1);
  wire [PW-1:0] pf_val = upd_we ? upd_val : {reg_wdata, reg_wdata};

  mrie_ptr_file #(
    .PW (PW)
  ) u_ptr_file (
    .core_clk (core_clk),
    .rst      (rst),
    .wr_en    (pf_we),
    .wr_idx   (pf_idx),
    .wr_be    (pf_be),
    .wr_val   (pf_val),
    .ptr0     (ptr0),
    .ptr1     (ptr1)
  );

  // Data memory write port, registered so outputs come from flip-flops
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mem_wr_en   <= 1'b0;
      mem_wr_addr <= {PW{1'b0}};
      mem_wr_data <= {DW{1'b0}};
    end else begin
      mem_wr_en <= ea_we;
      if (ea_we) begin
        mem_wr_addr <= ea;
        mem_wr_data <= w_reg;
      end
    end
  end

  // Sequencing: returns hold the pipe for a second, flush cycle
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state          <= ST_RUN;
      pc_advance     <= 1'b0;
      pc_load        <= 1'b0;
      pc_value       <= {PCW{1'b0}};
      stack_pop      <= 1'b0;
      soft_reset_req <= 1'b0;
    end else begin
      pc_advance     <= 1'b0;
      pc_load        <= 1'b0;
      stack_pop      <= 1'b0;
      soft_reset_req <= 1'b0;
      case (state)
        ST_RUN: begin
          if (take && (is_irt || is_srt)) begin
            stack_pop <= 1'b1;
            pc_load   <= 1'b1;
            pc_value  <= stack_top;
            state     <= ST_FLUSH;
          end else if (take && is_swr) begin
            soft_reset_req <= 1'b1;
          end else if (take && (is_dir || is_ind || is_rel ||
                                is_nop || is_opt)) begin
            pc_advance <= 1'b1;
          end
        end
        ST_FLUSH: begin
          state <= ST_RUN;
        end
        default: begin
          state <= ST_RUN;
        end
      endcase
    end
  end

  // Option, power control and interrupt control; instruction effects win
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      option_reg        <= `MRIE_OPTION_RST;
      reset_instr_flag  <= `MRIE_RI_RST;
      global_irq_enable <= `MRIE_GIE_RST;
    end else begin
      if (reg_wr && reg_addr == `MRIE_REG_OPTION)
        option_reg <= reg_wdata;
      if (reg_wr && reg_addr == `MRIE_REG_PWRCTL)
        reset_instr_flag <= reg_wdata[`MRIE_RI_BIT];
      if (reg_wr && reg_addr == `MRIE_REG_IRQCTL)
        global_irq_enable <= reg_wdata[`MRIE_GIE_BIT];
      // Instruction effects come last so they override a same-cycle write
      if (take && is_opt)
        option_reg <= w_reg;
      if (take && is_swr)
        reset_instr_flag <= 1'b0;
      if (take && is_irt)
        global_irq_enable <= 1'b1;
    end
  end

  // Combinational read selection for the register port
  reg [DW-1:0] rd_mux;

  // Read mux; unmapped addresses read as zero
  always @* begin
    rd_mux = {DW{1'b0}};
    case (reg_addr)
      `MRIE_REG_PTR0_LO: rd_mux = ptr0[HW-1:0];
      `MRIE_REG_PTR0_HI: rd_mux = ptr0[PW-1:HW];
      `MRIE_REG_PTR1_LO: rd_mux = ptr1[HW-1:0];
      `MRIE_REG_PTR1_HI: rd_mux = ptr1[PW-1:HW];
      `MRIE_REG_OPTION:  rd_mux = option_reg;
      `MRIE_REG_PWRCTL:  rd_mux[`MRIE_RI_BIT] = reset_instr_flag;
      `MRIE_REG_IRQCTL:  rd_mux[`MRIE_GIE_BIT] = global_irq_enable;
      default:           rd_mux = {DW{1'b0}};
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge core_clk or posedge rst) begin
    if (rst)
      reg_rdata <= {DW{1'b0}};
    else if (reg_rd)
      reg_rdata <= rd_mux;
    else
      reg_rdata <= {DW{1'b0}};
  end

endmodule // mrie_exec
`default_nettype wire

// [inc/mrie_consts.vh]
// Constants for the move and return instruction execution block
`ifndef MRIE_CONSTS_VH
`define MRIE_CONSTS_VH

// Instruction word width and opcode patterns
`define MRIE_IW            14
`define MRIE_DIR_MASK      14'h3f80
`define MRIE_DIR_MATCH     14'h0100
`define MRIE_IND_MASK      14'h3ff8
`define MRIE_IND_MATCH     14'h0020
`define MRIE_REL_MASK      14'h3f80
`define MRIE_REL_MATCH     14'h0380
`define MRIE_OP_NOP        14'h0000
`define MRIE_OP_OPTION     14'h0040
`define MRIE_OP_SWRESET    14'h0041
`define MRIE_OP_IRQRET     14'h0042
`define MRIE_OP_SUBRET     14'h0043

// Operand field positions
`define MRIE_F_HI          6
`define MRIE_IND_SEL_BIT   2
`define MRIE_MODE_HI       1
`define MRIE_MODE_LO       0
`define MRIE_REL_SEL_BIT   6
`define MRIE_K_HI          5
`define MRIE_K_W           6

// Update mode field encodings
`define MRIE_MODE_PREINC   2'h0
`define MRIE_MODE_PREDEC   2'h1
`define MRIE_MODE_POSTINC  2'h2
`define MRIE_MODE_POSTDEC  2'h3

// File addresses of the two indirect data registers
`define MRIE_IND0_ADDR     7'h00
`define MRIE_IND1_ADDR     7'h01

// Register port indices
`define MRIE_REG_PTR0_LO   3'h0
`define MRIE_REG_PTR0_HI   3'h1
`define MRIE_REG_PTR1_LO   3'h2
`define MRIE_REG_PTR1_HI   3'h3
`define MRIE_REG_OPTION    3'h4
`define MRIE_REG_PWRCTL    3'h5
`define MRIE_REG_IRQCTL    3'h6

// Field positions and reset values
`define MRIE_RI_BIT        0
`define MRIE_GIE_BIT       7
`define MRIE_OPTION_RST    8'hff
`define MRIE_RI_RST        1'h1
`define MRIE_GIE_RST       1'h0
`define MRIE_PTR_RST       16'h0000

// Execution states
`define MRIE_ST_RUN        1'h0
`define MRIE_ST_FLUSH      1'h1

`endif

// [verilog/mrie_ptr_file.v]
// Two 16-bit pointer registers with byte-lane writes
`timescale 1ns/1ps
`default_nettype none
`include "mrie_consts.vh"

module mrie_ptr_file #(
  parameter PW = 16
) (
  input  wire          core_clk,
  input  wire          rst,
  input  wire          wr_en,
  input  wire          wr_idx,
  input  wire [1:0]    wr_be,
  input  wire [PW-1:0] wr_val,
  output reg  [PW-1:0] ptr0,
  output reg  [PW-1:0] ptr1
);

  localparam HW = PW / 2;

  // Each lane writes on its own so the port can update one byte at a time
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ptr0 <= `MRIE_PTR_RST;
      ptr1 <= `MRIE_PTR_RST;
    end else if (wr_en) begin
      if (!wr_idx) begin
        if (wr_be[0]) ptr0[HW-1:0]  <= wr_val[HW-1:0];
        if (wr_be[1]) ptr0[PW-1:HW] <= wr_val[PW-1:HW];
      end else begin
        if (wr_be[0]) ptr1[HW-1:0]  <= wr_val[HW-1:0];
        if (wr_be[1]) ptr1[PW-1:HW] <= wr_val[PW-1:HW];
      end
    end
  end

endmodule // mrie_ptr_file
`default_nettype wire

// [testbench/mrie_exec_asserts.sv]
// Assertions on the instruction port of the move and return block
`timescale 1ns/1ps
`default_nettype none
`include "mrie_consts.vh"

module mrie_exec_asserts (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic [13:0] instr_word,
  input wire logic        instr_valid,
  input wire logic        instr_ready,
  input wire logic [7:0]  w_reg,
  input wire logic [14:0] stack_top,
  input wire logic        mem_wr_en,
  input wire logic [15:0] mem_wr_addr,
  input wire logic [7:0]  mem_wr_data,
  input wire logic        pc_advance,
  input wire logic        pc_load,
  input wire logic [14:0] pc_value,
  input wire logic        stack_pop,
  input wire logic        soft_reset_req,
  input wire logic [7:0]  option_reg,
  input wire logic        reset_instr_flag,
  input wire logic        global_irq_enable,
  input wire logic [15:0] pointer_0,
  input wire logic [15:0] pointer_1
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Take strobe and relative effective address, sign extended offset
  wire logic        tk = instr_valid && instr_ready;
  wire logic [15:0] rel_ea = (instr_word[6] ? pointer_1 : pointer_0)
                             + {{10{instr_word[5]}}, instr_word[5:0]};

  a_dir_store: assert property (tk && instr_word[13:7] == 7'h02 &&
    instr_word[6:1] != 6'h00 |=> mem_wr_en && pc_advance &&
    mem_wr_addr == {9'h000, $past(instr_word[6:0])} &&
    mem_wr_data == $past(w_reg)) else $error("direct store wrong");
  a_postinc_ptr0: assert property (tk && instr_word == 14'h0022 |=>
    mem_wr_addr == $past(pointer_0) && pointer_0 == $past(pointer_0) + 16'h1)
    else $error("post increment wrong");
  a_predec_ptr1: assert property (tk && instr_word == 14'h0025 |=>
    pointer_1 == $past(pointer_1) - 16'h1 && mem_wr_addr == pointer_1)
    else $error("pre decrement wrong");
  a_rel_keep: assert property (tk && instr_word[13:7] == 7'h07 |=>
    mem_wr_en && mem_wr_addr == $past(rel_ea) && $stable(pointer_0) &&
    $stable(pointer_1)) else $error("relative store wrong");
  a_opt_load: assert property (tk && instr_word == `MRIE_OP_OPTION |=>
    option_reg == $past(w_reg) && pc_advance && !mem_wr_en)
    else $error("option load wrong");
  a_sw_reset: assert property (tk && instr_word == `MRIE_OP_SWRESET |=>
    soft_reset_req && !reset_instr_flag) else $error("soft reset wrong");
  a_irq_return: assert property (tk && instr_word == `MRIE_OP_IRQRET
    |=> pc_load && stack_pop && global_irq_enable &&
    pc_value == $past(stack_top)) else $error("interrupt return wrong");
  a_ret_two_cycle: assert property (tk &&
    (instr_word == `MRIE_OP_IRQRET || instr_word == `MRIE_OP_SUBRET)
    |=> !instr_ready && stack_pop ##1 instr_ready)
    else $error("return length wrong");
  a_nop_quiet: assert property (tk && instr_word == `MRIE_OP_NOP |=>
    pc_advance && !mem_wr_en && !pc_load && !soft_reset_req &&
    $stable(pointer_0)) else $error("nop had side effect");
  a_ind_alias: assert property (tk && instr_word == 14'h0100 |=>
    mem_wr_en && mem_wr_addr == $past(pointer_0))
    else $error("indirect alias store wrong");
  a_sub_return: assert property (tk && instr_word == `MRIE_OP_SUBRET
    |=> pc_load && stack_pop && pc_value == $past(stack_top))
    else $error("subroutine return wrong");
endmodule // mrie_exec_asserts

bind mrie_exec mrie_exec_asserts u_chk (.core_clk, .rst, .instr_word,
  .instr_valid, .instr_ready, .w_reg, .stack_top, .mem_wr_en, .mem_wr_addr,
  .mem_wr_data, .pc_advance, .pc_load, .pc_value, .stack_pop, .soft_reset_req,
  .option_reg, .reset_instr_flag, .global_irq_enable, .pointer_0, .pointer_1);
`default_nettype wire

// [testbench/tb_top.sv]
// Self-checking bench for the move and return block
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic [13:0] instr_word = 14'h0000;
  logic        instr_valid = 1'b0;
  logic [7:0]  w_reg = 8'h00;
  logic [14:0] stack_top = 15'h0000;
  logic [2:0]  reg_addr = 3'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  wire         instr_ready, mem_wr_en, pc_advance, pc_load, stack_pop;
  wire         soft_reset_req, reset_instr_flag, global_irq_enable;
  wire  [15:0] mem_wr_addr, pointer_0, pointer_1;
  wire  [7:0]  mem_wr_data, option_reg, reg_rdata;
  wire  [14:0] pc_value;
  integer      miscompares = 0;
  integer      cmp_count = 0;

  mrie_exec dut (.core_clk, .rst, .instr_word, .instr_valid, .instr_ready,
    .w_reg, .stack_top, .mem_wr_en, .mem_wr_addr, .mem_wr_data, .pc_advance,
    .pc_load, .pc_value, .stack_pop, .soft_reset_req, .option_reg,
    .reset_instr_flag, .global_irq_enable, .pointer_0, .pointer_1, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);

  // 125 MHz core clock
  always #4 core_clk = ~core_clk;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk({15'h0000, got}, {15'h0000, exp});
  endtask

  // One-cycle register write strobe
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk({8'h00, reg_rdata}, {8'h00, e});
  endtask

  // Offer one word; W also seeds the stack top so returns can be checked
  task automatic ex(input logic [13:0] wd, input logic [7:0] w,
                    input logic we, input logic [15:0] a);
    @(posedge core_clk);
    instr_word <= wd;
    instr_valid <= 1'b1;
    w_reg <= w;
    stack_top <= {w, 7'h2b};
    @(posedge core_clk);
    instr_valid <= 1'b0;
    #1 chk1(mem_wr_en, we);
    if (we) begin
      chk(mem_wr_addr, a);
      chk({8'h00, mem_wr_data}, {8'h00, w});
    end
  endtask

  task automatic wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Cut a hang short well beyond the roughly 70 cycles of the tests
  initial begin
    repeat (3000) @(posedge core_clk);
    miscompares++;
    wrap_up;
  end

  initial begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    rd(3'h4, 8'hff);
    rd(3'h5, 8'h01);
    rd(3'h6, 8'h00);
    rd(3'h7, 8'h00);
    wr(3'h0, 8'hff);
    wr(3'h1, 8'hff);
    ex(14'h0020, 8'h5a, 1'b1, 16'h0000);
    chk(pointer_0, 16'h0000);
    ex(14'h0025, 8'h11, 1'b1, 16'hffff);
    chk(pointer_1, 16'hffff);
    wr(3'h2, 8'h34);
    wr(3'h3, 8'h12);
    ex(14'h0026, 8'h22, 1'b1, 16'h1234);
    chk(pointer_1, 16'h1235);
    ex(14'h0027, 8'h33, 1'b1, 16'h1235);
    chk(pointer_1, 16'h1234);
    ex(14'h0022, 8'h44, 1'b1, 16'h0000);
    chk(pointer_0, 16'h0001);
    ex(14'h03e0, 8'h55, 1'b1, 16'h1214);
    chk(pointer_1, 16'h1234);
    ex(14'h039f, 8'h66, 1'b1, 16'h0020);
    chk(pointer_0, 16'h0001);
    ex(14'h017f, 8'h77, 1'b1, 16'h007f);
    ex(14'h0101, 8'h88, 1'b1, 16'h1234);
    ex(14'h0100, 8'hab, 1'b1, 16'h0001);
    ex(14'h0000, 8'h99, 1'b0, 16'h0000);
    chk1(pc_advance, 1'b1);
    ex(14'h0040, 8'h4f, 1'b0, 16'h0000);
    chk({8'h00, option_reg}, 16'h004f);
    rd(3'h4, 8'h4f);
    ex(14'h0041, 8'h00, 1'b0, 16'h0000);
    chk1(soft_reset_req, 1'b1);
    chk1(reset_instr_flag, 1'b0);
    rd(3'h5, 8'h00);
    ex(14'h0042, 8'h3c, 1'b0, 16'h0000);
    chk({13'h0000, pc_load, stack_pop, instr_ready}, 16'h0006);
    chk({1'b0, pc_value}, {1'b0, 8'h3c, 7'h2b});
    chk1(global_irq_enable, 1'b1);
    ex(14'h0043, 8'h5d, 1'b0, 16'h0000);
    chk({13'h0000, pc_load, stack_pop, instr_ready}, 16'h0006);
    chk({1'b0, pc_value}, {1'b0, 8'h5d, 7'h2b});
    rd(3'h6, 8'h80);
    wr(3'h6, 8'h00);
    rd(3'h6, 8'h00);
    wr(3'h5, 8'h01);
    rd(3'h5, 8'h01);
    wrap_up;
  end
endmodule // tb_top
`default_nettype wire
